// ---- rtl/rfs_defs.svh ----
// timing counts and reset values for the reset and float mode sequencer
`ifndef RFS_DEFS_SVH
`define RFS_DEFS_SVH
`define RFS_CLK_MHZ        50
`define RFS_FETCH_CYCLES   80
`define RFS_FLOAT_CYCLES   80
`define RFS_MIN_CLK_CYCLES 10
`define RFS_FETCH_ADDR     32'h0000_0000
`define RFS_BOOT_RST       1'b0
`define RFS_FLOAT_RST      1'b0
`define RFS_IO_FUNC_RST    1'b0
`endif

// ---- rtl/rfs_pkg.sv ----
// types for the reset and float mode sequencer
package rfs_pkg;
	typedef enum logic [1:0] {
		RFS_ST_RESET = 2'b00,
		RFS_ST_WAIT  = 2'b01,
		RFS_ST_RUN   = 2'b10
	} rfs_state_t;
endpackage : rfs_pkg

// ---- rtl/rfs_rst_sync.sv ----
// reset release synchroniser: asynchronous assert, clocked release
`timescale 1ns/1ns
`default_nettype none
module rfs_rst_sync #(
	parameter int STAGES = 3
) (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	output logic      srst_n
);
	logic [STAGES-1:0] chain_r;

	// assert at once, release only after STAGES edges of the master clock
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			chain_r <= '0;
		end else begin
			chain_r <= {chain_r[STAGES-2:0], 1'b1};
		end
	end

	assign srst_n = chain_r[STAGES-1];
endmodule : rfs_rst_sync
`default_nettype wire

// ---- rtl/rfs_sequencer.sv ----
// reset and float mode sequencer top
`timescale 1ns/1ns
`default_nettype none
`include "rfs_defs.svh"

module rfs_sequencer
	import rfs_pkg::*;
#(
	parameter int          FETCH_CYCLES = `RFS_FETCH_CYCLES,
	parameter int          FLOAT_CYCLES = `RFS_FLOAT_CYCLES,
	parameter int          NUM_IO       = 32,
	parameter logic [31:0] FETCH_ADDR   = `RFS_FETCH_ADDR
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              ext_reset_n,
	input  wire logic              wdog_reset_req,
	input  wire logic              boot_select,
	input  wire logic              float_select_n,
	input  wire logic              clk_out_as_gpio,
	input  wire logic              io_line_21_oe,
	input  wire logic              io_line_21_out,
	input  wire logic              serial1_tx_en,
	input  wire logic              serial1_tx_out,
	input  wire logic [NUM_IO-1:0] periph_oe,
	output logic                   periph_rst_n,
	output logic                   core_rst_n,
	output logic                   fetch_start,
	output logic [31:0]            fetch_addr,
	output logic                   boot_mode,
	output logic                   float_mode,
	output logic [NUM_IO-1:0]      pin_oe,
	output logic                   pin21_out,
	output logic                   pin21_oe,
	output logic                   clk_out_pin,
	output logic                   clk_out_oe
);
	// ---------------------------------------------------------------
	// reset arbitration and synchronisation
	// ---------------------------------------------------------------
	logic arst_n;
	logic srst_n;
	logic ext_srst_n;
	logic wdog_hold_r;

	// watchdog request held until the reset really takes effect
	// a request in the cycle that clears the hold wins, so none is lost
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wdog_hold_r <= 1'b0;
		end else if (wdog_reset_req) begin
			wdog_hold_r <= 1'b1;
		end else if (!srst_n) begin
			wdog_hold_r <= 1'b0;
		end
	end

	// pin asserts at once; both sources reset srst_n logic, but only the pin reaches ext_srst_n and the mode capture
	assign arst_n = ext_reset_n & ~wdog_hold_r & rst_n;

	rfs_rst_sync #(.STAGES(3)) u_sync_all (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.srst_n  (srst_n)
	);

	rfs_rst_sync #(.STAGES(3)) u_sync_ext (
		.clk_sys (clk_sys),
		.arst_n  (ext_reset_n & rst_n),
		.srst_n  (ext_srst_n)
	);

	// ---------------------------------------------------------------
	// float select sampling window
	// ---------------------------------------------------------------
	// count of consecutive low samples while the pin reset is held
	logic [7:0] low_cnt_r;
	logic [2:0] fsel_sync_r;
	logic       fsel_low;

	always_ff @(posedge clk_sys) begin
		fsel_sync_r <= {fsel_sync_r[1:0], float_select_n};
	end
	assign fsel_low = ~fsel_sync_r[2] & ~fsel_sync_r[1];

	always_ff @(posedge clk_sys) begin
		if (!rst_n || ext_srst_n) begin
			low_cnt_r <= 8'h00;
		end else if (!fsel_low) begin
			low_cnt_r <= 8'h00;
		end else if (low_cnt_r != 8'(FLOAT_CYCLES)) begin
			low_cnt_r <= low_cnt_r + 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// mode capture: only on external reset release
	// ---------------------------------------------------------------
	logic boot_mode_r;
	logic float_mode_r;
	logic boot_smp_r;
	logic ext_prev_r;
	logic [2:0] boot_sync_r;

	// strap is a pin: three flops, a level counts once the last two agree
	always_ff @(posedge clk_sys) begin
		boot_sync_r <= {boot_sync_r[1:0], boot_select};
	end

	// boot select sampled while the pin holds reset, frozen otherwise
	// a disagreeing pair keeps the older sample rather than a metastable one
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			boot_smp_r <= `RFS_BOOT_RST;
		end else if (!ext_srst_n && (boot_sync_r[2] == boot_sync_r[1])) begin
			boot_smp_r <= boot_sync_r[2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ext_prev_r <= 1'b0;
		end else begin
			ext_prev_r <= ext_srst_n;
		end
	end

	// watchdog release never updates the modes; pin release always does
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			boot_mode_r  <= `RFS_BOOT_RST;
			float_mode_r <= `RFS_FLOAT_RST;
		end else if (ext_srst_n && !ext_prev_r) begin
			boot_mode_r  <= boot_smp_r;
			float_mode_r <= (low_cnt_r >= 8'(FLOAT_CYCLES - 3));
		end
	end

	assign boot_mode  = boot_mode_r;
	assign float_mode = float_mode_r;

	// ---------------------------------------------------------------
	// release and first fetch timing
	// ---------------------------------------------------------------
	rfs_state_t state_r;
	logic [7:0] fetch_cnt_r;
	logic       fetch_start_r;

	// synchroniser eats 3 of the 80 cycles, counted here as the rest
	always_ff @(posedge clk_sys) begin
		if (!srst_n) begin
			state_r       <= RFS_ST_RESET;
			fetch_cnt_r   <= 8'h00;
			fetch_start_r <= 1'b0;
		end else begin
			fetch_start_r <= 1'b0;
			case (state_r)
				RFS_ST_RESET: begin
					state_r     <= RFS_ST_WAIT;
					fetch_cnt_r <= 8'h04;
				end
				RFS_ST_WAIT: begin
					if (fetch_cnt_r == 8'(FETCH_CYCLES)) begin
						state_r       <= RFS_ST_RUN;
						fetch_start_r <= 1'b1;
					end else begin
						fetch_cnt_r <= fetch_cnt_r + 8'h01;
					end
				end
				RFS_ST_RUN: begin
					state_r <= RFS_ST_RUN;
				end
				default: begin
					state_r <= RFS_ST_RESET;
				end
			endcase
		end
	end

	assign fetch_start  = fetch_start_r;
	assign fetch_addr   = FETCH_ADDR;
	assign periph_rst_n = srst_n;
	// only the program counter is defined; core reset waits for the fetch
	// gated by the synced reset so a watchdog stops the core on the clock edge after its request
	assign core_rst_n   = srst_n & ((state_r == RFS_ST_RUN) | fetch_start_r);

	// ---------------------------------------------------------------
	// pad control
	// ---------------------------------------------------------------
	logic in_reset;
	assign in_reset = ~srst_n;

	// drivers off in reset, and always in tri-state mode
	assign pin_oe = (in_reset || float_mode_r) ? '0 : periph_oe;

	// shared pin: input while sampled, muxed functions only after reset
	assign pin21_oe  = ~in_reset & ~float_mode_r
	                 & (serial1_tx_en | io_line_21_oe);
	assign pin21_out = serial1_tx_en ? serial1_tx_out : io_line_21_out;

	// clock copy; a gate on the clock path is accepted at the pad only
	assign clk_out_pin = clk_sys;
	assign clk_out_oe  = ~float_mode_r & (in_reset | ~clk_out_as_gpio);
endmodule : rfs_sequencer
`default_nettype wire

// ---- verif/rfs_sva.sv ----
// assertion checker for the reset and float mode sequencer
`timescale 1ns/1ns
`default_nettype none
module rfs_sva #(
	parameter int NUM_IO = 32
) (
	input wire logic              clk_sys,
	input wire logic              rst_n,
	input wire logic              ext_reset_n,
	input wire logic              wdog_reset_req,
	input wire logic              periph_rst_n,
	input wire logic              fetch_start,
	input wire logic [31:0]       fetch_addr,
	input wire logic              boot_mode,
	input wire logic              float_mode,
	input wire logic [NUM_IO-1:0] pin_oe,
	input wire logic              pin21_oe,
	input wire logic              clk_out_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// sync phase may move the fetch by two clocks either way
	sequence s_rel; $rose(ext_reset_n); endsequence
	sequence s_fetch; ##[78:82] fetch_start; endsequence
	a_fetch_delay: assert property (s_rel |-> s_fetch) else $error("fetch late");
	a_oe_reset: assert property (!periph_rst_n |-> ~|pin_oe) else $error("oe in reset");
	a_fetch_addr: assert property (fetch_start |-> fetch_addr == 32'h0) else $error("addr");
	a_async_assert: assert property (!ext_reset_n |-> !periph_rst_n) else $error("async");
	a_sync_release: assert property ($rose(periph_rst_n) |-> $past(ext_reset_n, 2))
		else $error("early release");
	a_wdog_keeps_mode: assert property (wdog_reset_req && ext_reset_n |=>
		($stable({boot_mode, float_mode}))[*8]) else $error("mode moved");
	a_float_off: assert property (float_mode |-> ~|pin_oe && !pin21_oe && !clk_out_oe)
		else $error("driver on");
	a_clk_out_on: assert property (!periph_rst_n && !float_mode |-> clk_out_oe)
		else $error("clock out off");
endmodule : rfs_sva
`default_nettype wire

// ---- verif/rfs_board.sv ----
// board model: reset pin and boot and float straps
`timescale 1ns/1ns
`default_nettype none
module rfs_board (
	input  wire logic clk_sys,
	output logic      ext_reset_n,
	output logic      float_select_n,
	output logic      boot_select
);
	initial {ext_reset_n, float_select_n, boot_select} = 3'h6;
	// straps let go 6 clocks past release: pull-up on float, boot flips
	task automatic pulse(input int n, input logic flt, input logic bt);
		@(negedge clk_sys);
		{ext_reset_n, float_select_n, boot_select} = {1'b0, !flt, bt};
		repeat (n) @(negedge clk_sys);
		ext_reset_n = 1'b1;
		repeat (6) @(negedge clk_sys);
		{float_select_n, boot_select} = {1'b1, !bt};
	endtask : pulse
endmodule : rfs_board
`default_nettype wire

// ---- verif/rfs_sequencer_tb_top.sv ----
// self-checking bench for the reset and float mode sequencer
`timescale 1ns/1ns
`default_nettype none
module rfs_sequencer_tb_top;
	logic        clk_sys = 1'b0, rst_n = 1'b0, wdog_reset_req = 1'b0;
	logic        clk_out_as_gpio = 1'b0, io_line_21_oe = 1'b0, io_line_21_out = 1'b0;
	logic        serial1_tx_en = 1'b0, serial1_tx_out = 1'b0;
	logic [31:0] periph_oe = 32'h0, pin_oe, fetch_addr;
	logic        fetch_start, boot_mode, float_mode, periph_rst_n, pin21_oe, clk_out_oe;
	logic        core_rst_n, pin21_out, clk_out_pin;
	wire logic   ext_reset_n, float_select_n, boot_select;
	logic [1:0]  exp_q[$];
	integer      seed = 32'h36660284;
	int          bad_count = 0, cmp_count = 0;
	always #10 clk_sys = !clk_sys;
	rfs_board board (
		.clk_sys        (clk_sys),
		.ext_reset_n    (ext_reset_n),
		.float_select_n (float_select_n),
		.boot_select    (boot_select)
	);
	rfs_sequencer uut (
		.clk_sys         (clk_sys),
		.rst_n           (rst_n),
		.ext_reset_n     (ext_reset_n),
		.wdog_reset_req  (wdog_reset_req),
		.boot_select     (boot_select),
		.float_select_n  (float_select_n),
		.clk_out_as_gpio (clk_out_as_gpio),
		.io_line_21_oe   (io_line_21_oe),
		.io_line_21_out  (io_line_21_out),
		.serial1_tx_en   (serial1_tx_en),
		.serial1_tx_out  (serial1_tx_out),
		.periph_oe       (periph_oe),
		.periph_rst_n    (periph_rst_n),
		.core_rst_n      (core_rst_n),
		.fetch_start     (fetch_start),
		.fetch_addr      (fetch_addr),
		.boot_mode       (boot_mode),
		.float_mode      (float_mode),
		.pin_oe          (pin_oe),
		.pin21_out       (pin21_out),
		.pin21_oe        (pin21_oe),
		.clk_out_pin     (clk_out_pin),
		.clk_out_oe      (clk_out_oe)
	);
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results
	initial begin
		repeat (3000) @(posedge clk_sys);
		bad_count++;
		results();
	end
	// look 5 ns past the edge so process order never matters
	always @(posedge clk_sys) begin
		#5;
		check(clk_out_pin, 1'b1);
		if (periph_rst_n === 1'b0) begin
			check(pin_oe, 32'h0);
			check(pin21_oe, 1'b0);
			check(core_rst_n, 1'b0);
		end
		if (fetch_start === 1'b1) check(core_rst_n, 1'b1);
		if (fetch_start === 1'b1 && exp_q.size() > 0) begin
			check({boot_mode, float_mode}, exp_q.pop_front());
		end
	end
	initial begin
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		for (int i = 0; i < 4; i++) begin
			periph_oe = $random(seed);
			{clk_out_as_gpio, io_line_21_oe, io_line_21_out} = 3'($random(seed));
			{serial1_tx_en, serial1_tx_out} = 2'($random(seed));
			exp_q.push_back(i[1:0]);
			board.pulse(90 + i, i[0], i[1]);
			repeat (90) @(negedge clk_sys);
			check(pin_oe, i[0] ? 32'h0 : periph_oe);
			check(pin21_oe, !i[0] && (serial1_tx_en || io_line_21_oe));
			check(pin21_out, serial1_tx_en ? serial1_tx_out : io_line_21_out);
			check(clk_out_oe, !i[0] && !clk_out_as_gpio);
			check(core_rst_n, 1'b1);
			check(exp_q.size(), 32'h0);
			$display("boot case %0d done", i);
		end
		wdog_reset_req = 1'b1;
		@(negedge clk_sys);
		wdog_reset_req = 1'b0;
		repeat (100) @(negedge clk_sys);
		check({boot_mode, float_mode}, 32'h3);
		$display("watchdog case done");
		exp_q.push_back(2'h0);
		fork
			board.pulse(100, 1'b0, 1'b0);
			begin
				repeat (5) @(negedge clk_sys);
				wdog_reset_req = 1'b1;
				@(negedge clk_sys);
				wdog_reset_req = 1'b0;
			end
		join
		repeat (90) @(negedge clk_sys);
		check(exp_q.size(), 32'h0);
		$display("priority case done");
		results();
	end
endmodule : rfs_sequencer_tb_top
bind rfs_sequencer rfs_sva #(.NUM_IO(NUM_IO)) chk (
	.clk_sys        (clk_sys),
	.rst_n          (rst_n),
	.ext_reset_n    (ext_reset_n),
	.wdog_reset_req (wdog_reset_req),
	.periph_rst_n   (periph_rst_n),
	.fetch_start    (fetch_start),
	.fetch_addr     (fetch_addr),
	.boot_mode      (boot_mode),
	.float_mode     (float_mode),
	.pin_oe         (pin_oe),
	.pin21_oe       (pin21_oe),
	.clk_out_oe     (clk_out_oe)
);
`default_nettype wire
